// ==== rtl/nibble_alu_and_branch_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_and_branch_unit
	import nibble_alu_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire nibble_alu_pkg::instr_t instr,
	output nibble_alu_pkg::ram_wr_t ram_wr,
	output logic [nibble_alu_pkg::NIB_W-1:0] main_operand_reg,
	output logic [nibble_alu_pkg::NIB_W-1:0] scratch_reg,
	output logic carry_bit,
	output logic zero_result_bit,
	output logic [nibble_alu_pkg::ADDR_W-1:0] instruction_pointer,
	output logic skip_active
);
	import nibble_alu_pkg::*;

	logic [NIB_W-1:0] mreg_r, mreg_nxt;
	logic [NIB_W-1:0] scr_r, scr_nxt;
	logic carry_r, carry_nxt;
	logic zero_r, zero_nxt;
	logic [ADDR_W-1:0] ip_r, ip_nxt;
	ram_wr_t ram_r, ram_nxt;
	seq_state_t st_r, st_nxt;
	logic [NIB_W:0] sum;
	logic [NIB_W-1:0] res;
	logic upd;
	logic take;
	logic imm_form;
	logic run_valid;
	logic skip_valid;
	logic bit_hit;

	// Datapath and sequencing
	always_comb begin
		mreg_nxt = mreg_r;
		scr_nxt = scr_r;
		carry_nxt = carry_r;
		zero_nxt = zero_r;
		ip_nxt = ip_r;
		st_nxt = st_r;
		ram_nxt = '{we: 1'b0, data: ram_r.data};
		sum = '0;
		res = '0;
		upd = 1'b0;
		take = 1'b0;
		imm_form = 1'b0;
		if (instr.valid) begin
			ip_nxt = ip_r + IP_STEP;
			if (st_r == ST_SKIP) begin
				st_nxt = ST_RUN;
			end else begin
				case (instr.op)
					OP_ADC_REG, OP_ADC_STORE: begin
						sum = {1'b0, instr.ram_data} + {1'b0, mreg_r} +
							{{NIB_W{1'b0}}, carry_r};
						upd = 1'b1;
						ram_nxt.we = (instr.op == OP_ADC_STORE);
					end
					OP_ADC_IMM_STORE: begin
						sum = {1'b0, scr_r} + {1'b0, instr.imm} +
							{{NIB_W{1'b0}}, carry_r};
						upd = 1'b1;
						imm_form = 1'b1;
					end
					OP_SUB_REG, OP_SUB_STORE: begin
						sum = {1'b0, instr.ram_data} - {1'b0, mreg_r} -
							{{NIB_W{1'b0}}, carry_r};
						upd = 1'b1;
						ram_nxt.we = (instr.op == OP_SUB_STORE);
					end
					OP_SUB_IMM_STORE: begin
						sum = {1'b0, scr_r} - {1'b0, instr.imm} -
							{{NIB_W{1'b0}}, carry_r};
						upd = 1'b1;
						imm_form = 1'b1;
					end
					OP_DEC_SKIP_ZERO, OP_DEC_SKIP_NONZERO: begin
						sum = {1'b0, instr.ram_data} - {1'b0, NIB_ONE};
						upd = 1'b1;
						ram_nxt.we = 1'b1;
						if ((sum[NIB_W-1:0] == NIB_ZERO) ==
							(instr.op == OP_DEC_SKIP_ZERO)) begin
							st_nxt = ST_SKIP;
						end
					end
					OP_BRANCH_BIT: take = mreg_r[instr.bit_sel];
					OP_BRANCH_ZERO: take = (mreg_r == NIB_ZERO);
					OP_BRANCH_NONZERO: take = (mreg_r != NIB_ZERO);
					OP_BRANCH_CARRY: take = carry_r;
					OP_BRANCH_NO_CARRY: take = !carry_r;
					default: take = 1'b0;
				endcase
				res = sum[NIB_W-1:0];
				if (upd) begin
					mreg_nxt = res;
					carry_nxt = sum[CARRY_POS];
					zero_nxt = (res == NIB_ZERO);
					ram_nxt.data = res;
				end
				if (imm_form) begin
					scr_nxt = res;
				end
				if (take) begin
					ip_nxt = instr.target;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mreg_r <= NIB_ZERO;
			scr_r <= NIB_ZERO;
			carry_r <= 1'b0;
			zero_r <= 1'b0;
			ip_r <= IP_RESET;
			ram_r <= '0;
			st_r <= ST_RUN;
		end else begin
			mreg_r <= mreg_nxt;
			scr_r <= scr_nxt;
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
			ip_r <= ip_nxt;
			ram_r <= ram_nxt;
			st_r <= st_nxt;
		end
	end

	assign ram_wr = ram_r;
	assign main_operand_reg = mreg_r;
	assign scratch_reg = scr_r;
	assign carry_bit = carry_r;
	assign zero_result_bit = zero_r;
	assign instruction_pointer = ip_r;
	assign skip_active = (st_r == ST_SKIP);
	assign run_valid = instr.valid && (st_r == ST_RUN);
	assign skip_valid = instr.valid && (st_r == ST_SKIP);
	assign bit_hit = mreg_r[instr.bit_sel];

	// Checks
	a_skip_freezes_reg: assert property (
		@(posedge mclk) disable iff (!resetn)
		skip_valid |=> $stable(mreg_r) && $stable(carry_r) &&
		$stable(zero_r) && $stable(scr_r))
		else $error("skipped instruction changed state");
	a_skip_no_write: assert property (
		@(posedge mclk) disable iff (!resetn)
		skip_valid |=>
		!ram_r.we)
		else $error("skipped instruction wrote ram");
	a_skip_ip_step: assert property (
		@(posedge mclk) disable iff (!resetn)
		skip_valid |=>
		(ip_r == $past(ip_r) + IP_STEP) && st_r == ST_RUN)
		else $error("skip did not step past instruction");
	a_adc_reg_sum: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_ADC_REG |=>
		{carry_r, mreg_r} == {1'b0, $past(instr.ram_data)} +
		{1'b0, $past(mreg_r)} + {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("add with carry result wrong");
	a_adc_no_ram: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_ADC_REG |=>
		!ram_r.we)
		else $error("register add wrote ram");
	a_adc_store_sum: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_ADC_STORE |=>
		{carry_r, mreg_r} == {1'b0, $past(instr.ram_data)} +
		{1'b0, $past(mreg_r)} + {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("add with carry store result wrong");
	a_store_writes: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_ADC_STORE |=>
		ram_r.we && ram_r.data == mreg_r)
		else $error("add store did not write ram");
	a_sub_diff: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_SUB_REG |=>
		{carry_r, mreg_r} == {1'b0, $past(instr.ram_data)} -
		{1'b0, $past(mreg_r)} - {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("subtract with borrow result wrong");
	a_sub_no_ram: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_SUB_REG |=>
		!ram_r.we)
		else $error("register subtract wrote ram");
	a_sub_store_diff: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_SUB_STORE |=>
		{carry_r, mreg_r} == {1'b0, $past(instr.ram_data)} -
		{1'b0, $past(mreg_r)} - {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("subtract store result wrong");
	a_sub_store_ram: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_SUB_STORE |=>
		ram_r.we && ram_r.data == mreg_r)
		else $error("subtract store did not write ram");
	a_imm_add_sum: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_ADC_IMM_STORE |=>
		{carry_r, mreg_r} == {1'b0, $past(scr_r)} +
		{1'b0, $past(instr.imm)} + {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("immediate add result wrong");
	a_imm_sub_diff: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_SUB_IMM_STORE |=>
		{carry_r, mreg_r} == {1'b0, $past(scr_r)} -
		{1'b0, $past(instr.imm)} - {{NIB_W{1'b0}}, $past(carry_r)})
		else $error("immediate subtract result wrong");
	a_imm_scratch: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op inside {OP_ADC_IMM_STORE, OP_SUB_IMM_STORE} |=>
		scr_r == mreg_r && !ram_r.we)
		else $error("immediate form missed scratch");
	a_zero_flag: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op inside {OP_ADC_REG, OP_ADC_STORE,
		OP_ADC_IMM_STORE, OP_SUB_REG, OP_SUB_STORE, OP_SUB_IMM_STORE,
		OP_DEC_SKIP_ZERO, OP_DEC_SKIP_NONZERO} |=>
		zero_r == (mreg_r == NIB_ZERO))
		else $error("zero flag wrong");
	a_dec_result: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op inside {OP_DEC_SKIP_ZERO,
		OP_DEC_SKIP_NONZERO} |=> {carry_r, mreg_r} ==
		{1'b0, $past(instr.ram_data)} - {1'b0, NIB_ONE})
		else $error("decrement result wrong");
	a_dec_write: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op inside {OP_DEC_SKIP_ZERO, OP_DEC_SKIP_NONZERO}
		|=> ram_r.we && ram_r.data == mreg_r)
		else $error("decrement did not write ram");
	a_deczero_skip: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_DEC_SKIP_ZERO &&
		instr.ram_data == NIB_ONE |=> st_r == ST_SKIP)
		else $error("decrement skip zero missed");
	a_deczero_run: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_DEC_SKIP_ZERO &&
		instr.ram_data != NIB_ONE |=> st_r == ST_RUN)
		else $error("decrement skip zero wrongly skipped");
	a_decnz_stay: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_DEC_SKIP_NONZERO &&
		instr.ram_data == NIB_ONE |=> st_r == ST_RUN)
		else $error("decrement skip nonzero wrongly skipped");
	a_decnz_skip: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_DEC_SKIP_NONZERO &&
		instr.ram_data != NIB_ONE |=> st_r == ST_SKIP)
		else $error("decrement skip nonzero missed");
	a_branch_bit: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_BIT |=> ip_r ==
		($past(bit_hit) ? $past(instr.target) : $past(ip_r) + IP_STEP))
		else $error("bit branch wrong");
	a_branch_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_ZERO && mreg_r == NIB_ZERO
		|=> ip_r == $past(instr.target))
		else $error("zero branch not taken");
	a_zero_falls: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_ZERO && mreg_r != NIB_ZERO
		|=> ip_r == $past(ip_r) + IP_STEP)
		else $error("zero branch wrongly taken");
	a_branch_nonzero: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_NONZERO && mreg_r != NIB_ZERO
		|=> ip_r == $past(instr.target))
		else $error("nonzero branch not taken");
	a_nonzero_falls: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_NONZERO && mreg_r == NIB_ZERO
		|=> ip_r == $past(ip_r) + IP_STEP)
		else $error("nonzero branch wrongly taken");
	a_branch_carry: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_CARRY |=> ip_r ==
		($past(carry_r) ? $past(instr.target) : $past(ip_r) + IP_STEP))
		else $error("carry branch wrong");
	a_branch_nocarry: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op == OP_BRANCH_NO_CARRY |=> ip_r ==
		(!$past(carry_r) ? $past(instr.target) : $past(ip_r) + IP_STEP))
		else $error("no carry branch wrong");
	a_branch_keeps: assert property (
		@(posedge mclk) disable iff (!resetn)
		run_valid && instr.op inside {OP_BRANCH_BIT, OP_BRANCH_ZERO,
		OP_BRANCH_NONZERO, OP_BRANCH_CARRY, OP_BRANCH_NO_CARRY} |=>
		$stable(mreg_r) && $stable(carry_r) && !ram_r.we)
		else $error("branch changed data state");
endmodule
`default_nettype wire

// ==== rtl/nibble_alu_pkg.sv ====
package nibble_alu_pkg;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 11;
	localparam logic [ADDR_W-1:0] IP_RESET = 11'h000;
	localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
	localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;
	localparam int CARRY_POS = 4;
	localparam logic [ADDR_W-1:0] IP_STEP = 11'h001;
	localparam logic [ADDR_W-1:0] IP_SKIP_STEP = 11'h002;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADC_REG = 4'h1,
		OP_ADC_STORE = 4'h2,
		OP_ADC_IMM_STORE = 4'h3,
		OP_SUB_REG = 4'h4,
		OP_SUB_STORE = 4'h5,
		OP_SUB_IMM_STORE = 4'h6,
		OP_DEC_SKIP_ZERO = 4'h7,
		OP_DEC_SKIP_NONZERO = 4'h8,
		OP_BRANCH_BIT = 4'h9,
		OP_BRANCH_ZERO = 4'ha,
		OP_BRANCH_NONZERO = 4'hb,
		OP_BRANCH_CARRY = 4'hc,
		OP_BRANCH_NO_CARRY = 4'hd
	} alu_op_t;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_SKIP = 1'b1
	} seq_state_t;

	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic [NIB_W-1:0] ram_data;
		logic [NIB_W-1:0] imm;
		logic [1:0] bit_sel;
		logic [ADDR_W-1:0] target;
	} instr_t;

	typedef struct packed {
		logic we;
		logic [NIB_W-1:0] data;
	} ram_wr_t;
endpackage

// ==== dv/ram_nibble_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ram_nibble_model
	import nibble_alu_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [nibble_alu_pkg::NIB_W-1:0] load_val,
	input wire nibble_alu_pkg::ram_wr_t ram_wr,
	output logic [nibble_alu_pkg::NIB_W-1:0] ram_data
);
	logic [NIB_W-1:0] mem_r;
	// Nibble takes the write-back
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			mem_r <= NIB_ZERO;
		else if (ram_wr.we)
			mem_r <= ram_wr.data;
	end
	assign ram_data = load ? load_val : mem_r;
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import nibble_alu_pkg::*;
	logic mclk = 1'b0, resetn = 1'b0, v = 1'b0, ld = 1'b0;
	logic [3:0] opb = 4'h0, rv = 4'h0, im = 4'h0, rd;
	logic [1:0] bs = 2'h0;
	logic [10:0] tg = 11'h000, instruction_pointer;
	instr_t instr;
	ram_wr_t ram_wr;
	logic [3:0] main_operand_reg, scratch_reg;
	logic carry_bit, zero_result_bit, skip_active;
	logic [3:0] e_mreg = 4'h0, e_scr = 4'h0;
	logic e_carry = 1'b0, e_zero = 1'b0, e_sk = 1'b0;
	logic [10:0] e_ip = 11'h000;
	int n_mismatch = 0;
	int samples_checked = 0;
	always #10 mclk = ~mclk;
	assign instr = {v, alu_op_t'(opb), rd, im, bs, tg};
	ram_nibble_model partner(.mclk, .resetn, .load(ld), .load_val(rv),
		.ram_wr, .ram_data(rd));
	nibble_alu_and_branch_unit dut(.mclk, .resetn, .instr, .ram_wr,
		.main_operand_reg, .scratch_reg, .carry_bit, .zero_result_bit,
		.instruction_pointer, .skip_active);
	task automatic chk(input string nm, input logic [10:0] e,
		input logic [10:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic issue(input alu_op_t o, input logic [3:0] r,
		input logic [3:0] i, input logic [1:0] b, input logic [10:0] t);
		logic [4:0] s;
		logic we;
		logic tk;
		s = 5'h00;
		we = 1'b0;
		tk = 1'b0;
		@(negedge mclk);
		{v, ld, opb, rv, im, bs, tg} <= {2'b11, o, r, i, b, t};
		if (e_sk) begin
			e_sk = 1'b0;
		end else begin
			case (o)
			OP_ADC_REG, OP_ADC_STORE: s = r + e_mreg + e_carry;
			OP_ADC_IMM_STORE: s = e_scr + i + e_carry;
			OP_SUB_REG, OP_SUB_STORE: s = r - e_mreg - e_carry;
			OP_SUB_IMM_STORE: s = e_scr - i - e_carry;
			OP_DEC_SKIP_ZERO, OP_DEC_SKIP_NONZERO: s = r - 5'h01;
			OP_BRANCH_BIT: tk = e_mreg[b];
			OP_BRANCH_ZERO: tk = (e_mreg == 4'h0);
			OP_BRANCH_NONZERO: tk = (e_mreg != 4'h0);
			OP_BRANCH_CARRY: tk = e_carry;
			default: tk = !e_carry;
			endcase
			if (o < OP_BRANCH_BIT) begin
				e_mreg = s[3:0];
				e_carry = s[4];
				e_zero = (s[3:0] == 4'h0);
			end
			if (o == OP_ADC_IMM_STORE || o == OP_SUB_IMM_STORE)
				e_scr = s[3:0];
			we = o inside {OP_ADC_STORE, OP_SUB_STORE, OP_DEC_SKIP_ZERO,
				OP_DEC_SKIP_NONZERO};
			if (o == OP_DEC_SKIP_ZERO || o == OP_DEC_SKIP_NONZERO)
				e_sk = (s[3:0] == 4'h0) == (o == OP_DEC_SKIP_ZERO);
		end
		e_ip = tk ? t : e_ip + 11'h001;
		@(negedge mclk);
		{v, ld} <= 2'b00;
		chk("mreg", e_mreg, main_operand_reg);
		chk("scratch", e_scr, scratch_reg);
		chk("carry", e_carry, carry_bit);
		chk("zero", e_zero, zero_result_bit);
		chk("ip", e_ip, instruction_pointer);
		chk("skip", e_sk, skip_active);
		chk("we", we, ram_wr.we);
		if (we)
			chk("wdata", s[3:0], ram_wr.data);
	endtask
	task automatic t_reset();
		issue(OP_ADC_IMM_STORE, 4'h0, 4'h7, 2'h0, 11'h000);
		resetn <= 1'b0;
		@(negedge mclk);
		resetn <= 1'b1;
		{e_mreg, e_scr, e_carry, e_zero, e_sk} = '0;
		e_ip = 11'h000;
		repeat (2) @(negedge mclk);
		chk("rst_mreg", e_mreg, main_operand_reg);
		chk("rst_scratch", e_scr, scratch_reg);
		chk("rst_carry", e_carry, carry_bit);
		chk("rst_zero", e_zero, zero_result_bit);
		chk("rst_ip", e_ip, instruction_pointer);
		chk("rst_skip", e_sk, skip_active);
		chk("rst_we", 11'h000, ram_wr.we);
	endtask
	task automatic t_add();
		issue(OP_ADC_REG, 4'h9, 4'h0, 2'h0, 11'h000);
		issue(OP_ADC_REG, 4'h7, 4'h0, 2'h0, 11'h000);
		issue(OP_ADC_STORE, 4'h3, 4'h0, 2'h0, 11'h000);
		issue(OP_ADC_IMM_STORE, 4'h0, 4'hf, 2'h0, 11'h000);
		issue(OP_ADC_IMM_STORE, 4'h0, 4'h1, 2'h0, 11'h000);
	endtask
	task automatic t_sub();
		issue(OP_SUB_REG, 4'h2, 4'h0, 2'h0, 11'h000);
		issue(OP_SUB_STORE, 4'h0, 4'h0, 2'h0, 11'h000);
		issue(OP_SUB_IMM_STORE, 4'h0, 4'h3, 2'h0, 11'h000);
	endtask
	task automatic t_dec();
		issue(OP_DEC_SKIP_ZERO, 4'h1, 4'h0, 2'h0, 11'h000);
		issue(OP_ADC_STORE, 4'h6, 4'h0, 2'h0, 11'h000);
		issue(OP_DEC_SKIP_ZERO, 4'h5, 4'h0, 2'h0, 11'h000);
		issue(OP_DEC_SKIP_NONZERO, 4'h0, 4'h0, 2'h0, 11'h000);
		issue(OP_BRANCH_CARRY, 4'h0, 4'h0, 2'h0, 11'h7ff);
		issue(OP_DEC_SKIP_NONZERO, 4'h1, 4'h0, 2'h0, 11'h000);
	endtask
	task automatic t_branch();
		issue(OP_ADC_REG, 4'h5, 4'h0, 2'h0, 11'h000);
		for (int k = 0; k < 4; k++) begin
			issue(OP_BRANCH_BIT, 4'h0, 4'h0, k[1:0], {9'h0a5, k[1:0]});
		end
		for (int n = 0; n < 2; n++) begin
			for (int k = 0; k < 4; k++) begin
				issue(alu_op_t'(OP_BRANCH_ZERO + k), 4'h0, 4'h0, 2'h0,
					{9'h15a, k[1:0]});
			end
			issue(OP_ADC_REG, 4'hb, 4'h0, 2'h0, 11'h000);
		end
	endtask
	task automatic stop_test();
		$display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		resetn <= 1'b1;
		t_add();
		t_sub();
		t_reset();
		t_dec();
		t_branch();
		stop_test();
	end
	initial begin
		#(20 * 1000);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
